// *** hdl/cms_pkg.sv ***
// constants for the mailbox and rx fifo status block
// assumes a 32-bit axi4-lite register bus
package cms_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned MB_NUM = 32;

    // ************************************************
    // register byte offsets
    // ************************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_INTEN = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h30;

    // ************************************************
    // field positions
    // ************************************************
    localparam int unsigned CTRL_FIFO_EN_BIT = 0;
    localparam int unsigned ST_OVF_BIT = 7;
    localparam int unsigned ST_AFULL_BIT = 6;
    localparam int unsigned ST_NEMPTY_BIT = 5;
    localparam int unsigned ST_RES_HI = 4;
    localparam int unsigned ST_RES_LO = 1;
    localparam int unsigned ST_CLR_BIT = 0;
    localparam int unsigned ST_MB_LO = 8;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [DATA_W-1:0] RST_STAT = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_INTEN = 32'h0000_0000;
    localparam logic RST_FIFO_EN = 1'h0;

    // ************************************************
    // bus response codes
    // ************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/cms_top.sv ***
// mailbox completion and rx fifo status flags with axi4-lite slave
// assumes the protocol engine gives one-cycle done and fifo event pulses on CLK
//
// Functional notes
// - Changing the rx fifo enable setting clears status bits 7 down to 1.
// - Bits 31 to 8 set when the mailbox with the same number completes.
// - Bit 7 is fifo overflow in fifo mode and mailbox 7 done otherwise.
// - Bit 6 is fifo almost full in fifo mode and mailbox 6 done otherwise.
// - Bit 5 follows fifo not empty in fifo mode and is mailbox 5 done otherwise.
// - Bits 4 to 1 are mailbox done flags without fifo and reserved with it.
// - In fifo mode writing one to bit 0 empties the fifo, only while inactive.
// - In fifo mode writing zero to bit 0 does nothing; otherwise it is mailbox 0 done.
// - The status register sits at 0x30 and resets to all zeros.
// - A flag interrupts only when its enable bit is set.
`timescale 1ns/1ns
`default_nettype none
module cms_top
    import cms_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CE,
    // mailbox and fifo events from the protocol engine
    input wire logic [cms_pkg::MB_NUM-1:0] MB_DONE,
    input wire logic FIFO_OVERFLOW,
    input wire logic FIFO_ALMOST_FULL,
    input wire logic FIFO_NONEMPTY,
    input wire logic INACTIVE_MODE,
    output logic FIFO_CLEAR,
    output logic RX_FIFO_EN,
    output logic IRQ,
    // axi4-lite slave
    input wire logic [cms_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [cms_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [cms_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [cms_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import cms_pkg::*;

    // ************************************************
    // declarations
    // ************************************************
    logic awready_r;
    logic wready_r;
    logic aw_full_r;
    logic w_full_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] stat_r;
    logic [DATA_W-1:0] stat_nxt;
    logic [DATA_W-1:0] inten_r;
    logic fifo_en_r;
    logic fifo_clr_r;
    logic irq_r;
    logic wr_go;
    logic [DATA_W-1:0] wmask;
    logic [DATA_W-1:0] wbits;
    logic wr_ctrl;
    logic wr_inten;
    logic wr_stat;
    logic mode_chg;
    logic [DATA_W-1:0] stat_view;
    logic [DATA_W-1:0] rd_val;
    logic rd_hit;
    logic wr_hit;
    logic [DATA_W-1:0] stat_set;
    logic [DATA_W-1:0] stat_clr;
    logic [DATA_W-1:0] irq_src;

    // ************************************************
    // write channel handshakes
    // ************************************************
    assign wr_go = aw_full_r && w_full_r && !bvalid_r;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            awready_r <= 1'b0;
            aw_full_r <= 1'b0;
            awaddr_r <= '0;
        end else if (CE) begin
            if (S_AXI_AWVALID && awready_r) begin
                awready_r <= 1'b0;
                aw_full_r <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
            end else if (wr_go) begin
                aw_full_r <= 1'b0;
            end else if (!aw_full_r && !bvalid_r) begin
                awready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wready_r <= 1'b0;
            w_full_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (CE) begin
            if (S_AXI_WVALID && wready_r) begin
                wready_r <= 1'b0;
                w_full_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end else if (wr_go) begin
                w_full_r <= 1'b0;
            end else if (!w_full_r && !bvalid_r) begin
                wready_r <= 1'b1;
            end
        end
    end

    // ************************************************
    // write decode
    // ************************************************
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wstrb_r[i]}};
        end
        wbits = wdata_r & wmask;
        wr_ctrl = wr_go && (awaddr_r[ADDR_W-1:2] == OFS_CTRL[ADDR_W-1:2]);
        wr_inten = wr_go && (awaddr_r[ADDR_W-1:2] == OFS_INTEN[ADDR_W-1:2]);
        wr_stat = wr_go && (awaddr_r[ADDR_W-1:2] == OFS_STAT[ADDR_W-1:2]);
        wr_hit = wr_ctrl || wr_inten || wr_stat;
        mode_chg = wr_ctrl && wmask[CTRL_FIFO_EN_BIT]
            && (wdata_r[CTRL_FIFO_EN_BIT] != fifo_en_r);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bvalid_r <= 1'b0;
        end else if (CE) begin
            if (wr_go) begin
                bvalid_r <= 1'b1;
            end else if (bvalid_r && S_AXI_BREADY) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // unmapped writes answer slave error and change nothing
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bresp_r <= RESP_OKAY;
        end else if (CE) begin
            if (wr_go) begin
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ************************************************
    // control and interrupt enable registers
    // ************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fifo_en_r <= RST_FIFO_EN;
        end else if (CE) begin
            if (mode_chg) begin
                fifo_en_r <= wdata_r[CTRL_FIFO_EN_BIT];
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            inten_r <= RST_INTEN;
        end else if (CE) begin
            if (wr_inten) begin
                inten_r <= (inten_r & ~wmask) | wbits;
            end
        end
    end

    // ************************************************
    // status flags
    // ************************************************
    always_comb begin
        stat_set = '0;
        stat_set[MB_NUM-1:ST_MB_LO] = MB_DONE[MB_NUM-1:ST_MB_LO];
        if (fifo_en_r) begin
            stat_set[ST_OVF_BIT] = FIFO_OVERFLOW;
            stat_set[ST_AFULL_BIT] = FIFO_ALMOST_FULL;
        end else begin
            stat_set[ST_MB_LO-1:0] = MB_DONE[ST_MB_LO-1:0];
        end
    end

    // strobed bytes of a status write clear
    always_comb begin
        stat_clr = '0;
        if (wr_stat) begin
            stat_clr = wbits;
        end
    end

    always_comb begin
        // set beats a status write clear in the same cycle; a mode change still clears bits 7 to 1
        stat_nxt = (stat_r & ~stat_clr) | stat_set;
        if (fifo_en_r) begin
            stat_nxt[ST_NEMPTY_BIT] = FIFO_NONEMPTY;
            stat_nxt[ST_RES_HI:ST_RES_LO] = '0;
            // mailbox 0 flag is parked, bit 0 is a command here
            stat_nxt[ST_CLR_BIT] = stat_r[ST_CLR_BIT];
        end
        if (mode_chg) begin
            stat_nxt[ST_OVF_BIT:ST_RES_LO] = '0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_r <= RST_STAT;
        end else if (CE) begin
            stat_r <= stat_nxt;
        end
    end

    // ************************************************
    // fifo clear command
    // ************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fifo_clr_r <= 1'b0;
        end else if (CE) begin
            // only taken while the controller is inactive
            fifo_clr_r <= wr_stat && fifo_en_r && wbits[ST_CLR_BIT] && INACTIVE_MODE;
        end
    end

    // ************************************************
    // interrupt
    // ************************************************
    // fifo mode hides the parked mailbox 0 flag behind the command bit
    always_comb begin
        stat_view = stat_r;
        if (fifo_en_r) begin
            stat_view[ST_CLR_BIT] = 1'b0;
        end
    end

    assign irq_src = stat_view & inten_r;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_r <= 1'b0;
        end else if (CE) begin
            irq_r <= |irq_src;
        end
    end

    // ************************************************
    // read channel
    // ************************************************
    always_comb begin
        rd_hit = 1'b1;
        rd_val = '0;
        if (S_AXI_ARADDR[ADDR_W-1:2] == OFS_CTRL[ADDR_W-1:2]) begin
            rd_val[CTRL_FIFO_EN_BIT] = fifo_en_r;
        end else if (S_AXI_ARADDR[ADDR_W-1:2] == OFS_INTEN[ADDR_W-1:2]) begin
            rd_val = inten_r;
        end else if (S_AXI_ARADDR[ADDR_W-1:2] == OFS_STAT[ADDR_W-1:2]) begin
            rd_val = stat_view;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            arready_r <= 1'b0;
        end else if (CE) begin
            if (S_AXI_ARVALID && arready_r) begin
                arready_r <= 1'b0;
            end else if (!rvalid_r) begin
                arready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rvalid_r <= 1'b0;
        end else if (CE) begin
            if (S_AXI_ARVALID && arready_r) begin
                rvalid_r <= 1'b1;
            end else if (rvalid_r && S_AXI_RREADY) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // read data is captured at the address handshake
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (CE) begin
            if (S_AXI_ARVALID && arready_r) begin
                rdata_r <= rd_val;
                rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = wready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RRESP = rresp_r;
    assign S_AXI_RDATA = rdata_r;
    assign FIFO_CLEAR = fifo_clr_r;
    assign RX_FIFO_EN = fifo_en_r;
    assign IRQ = irq_r;
endmodule
`default_nettype wire

// *** verification/cms_props.sv ***
// concurrent checks on the status block's bus and fifo-clear outputs
// assumes a single clock domain and the top module's port names
`timescale 1ns/1ns
`default_nettype none
module cms_props (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic INACTIVE_MODE,
    input wire logic FIFO_CLEAR,
    input wire logic RX_FIFO_EN,
    input wire logic IRQ,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // *****
    // properties
    // *****
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID; endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped early");
    property p_b_busy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    a_b_busy: assert property (p_b_busy) else $error("write taken during response");
    property p_r_busy; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_r_busy: assert property (p_r_busy) else $error("read taken during response");
    property p_clr_gate; $rose(FIFO_CLEAR) |-> $past(INACTIVE_MODE) && RX_FIFO_EN; endproperty
    a_clr_gate: assert property (p_clr_gate) else $error("fifo clear not allowed");
    property p_clr_pulse; FIFO_CLEAR |=> !FIFO_CLEAR; endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("fifo clear too long");
    property p_clr_resp; FIFO_CLEAR |-> S_AXI_BVALID; endproperty
    a_clr_resp: assert property (p_clr_resp) else $error("fifo clear without write");
    property p_en_write; $changed(RX_FIFO_EN) |-> S_AXI_BVALID; endproperty
    a_en_write: assert property (p_en_write) else $error("mode changed without write");
    c_clr: cover property (FIFO_CLEAR);
    c_irq: cover property ($rose(IRQ));
    c_mode: cover property ($rose(RX_FIFO_EN));
endmodule
bind cms_top cms_props u_props (.CLK(CLK), .ARST_N(ARST_N), .INACTIVE_MODE(INACTIVE_MODE),
    .FIFO_CLEAR(FIFO_CLEAR), .RX_FIFO_EN(RX_FIFO_EN), .IRQ(IRQ),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY));
`default_nettype wire

// *** verification/cms_engine_model.sv ***
// protocol engine stand-in: mailbox done pulses, fifo events and fill level
// assumes the bench calls its tasks and sets inactive directly
`timescale 1ns/1ns
`default_nettype none
module cms_engine_model (
    input wire logic clk,
    input wire logic fifo_clear,
    output logic [31:0] mb_done,
    output logic overflow,
    output logic almost_full,
    output logic nonempty,
    output logic inactive
);
    // *****
    // fifo fill and event pulses
    // *****
    int frames = 0;
    int clears = 0;
    initial begin
        mb_done = '0;
        overflow = 0;
        almost_full = 0;
        inactive = 0;
    end
    assign nonempty = (frames != 0);
    always @(posedge clk) begin
        if (fifo_clear) begin
            frames <= 0;
            clears <= clears + 1;
        end
    end
    task pulse(input logic [31:0] m, input logic ov, input logic af);
        @(posedge clk);
        mb_done <= m;
        overflow <= ov;
        almost_full <= af;
        @(posedge clk);
        mb_done <= '0;
        overflow <= 0;
        almost_full <= 0;
    endtask
    task push;
        @(posedge clk);
        frames <= frames + 1;
    endtask
endmodule
`default_nettype wire

// *** verification/can_mailbox_fifo_status_tb_top.sv ***
// self-checking bench for the mailbox and rx fifo status block
// assumes an axi4-lite master here and the engine model on the event side
`timescale 1ns/1ns
`default_nettype none
module can_mailbox_fifo_status_tb_top;
    import cms_pkg::*;
    // *****
    // clock, reset and wiring
    // *****
    logic clk = 0;
    logic arst_n = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, mb_done;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, fifo_clear, fifo_en, irq;
    logic ovf, afull, nempty, inact;
    logic [1:0] bresp, rresp;
    logic [1:0] last_bresp = '0;
    logic ce = 1;
    int n_errors = 0, n_compared = 0, cyc = 0;
    always #20 clk = ~clk;
    cms_top DUT (.CLK(clk), .ARST_N(arst_n), .CE(ce), .MB_DONE(mb_done),
        .FIFO_OVERFLOW(ovf), .FIFO_ALMOST_FULL(afull), .FIFO_NONEMPTY(nempty),
        .INACTIVE_MODE(inact), .FIFO_CLEAR(fifo_clear), .RX_FIFO_EN(fifo_en), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    cms_engine_model eng (.clk(clk), .fifo_clear(fifo_clear), .mb_done(mb_done),
        .overflow(ovf), .almost_full(afull), .nonempty(nempty), .inactive(inact));
    // *****
    // bus and compare tasks
    // *****
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        last_bresp = bresp;
        bready <= 0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0] r;
        rd(a, v, r);
        chk(v, exp);
    endtask
    task irq_is(input logic e);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    // *****
    // scenarios
    // *****
    task t_reset;
        logic [31:0] v;
        logic [1:0] r;
        rchk(OFS_STAT, RST_STAT);
        rchk(OFS_INTEN, RST_INTEN);
        rd(8'h44, v, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(v, 32'h0);
        wr(8'h44, 32'hFFFF_FFFF);
        chk({30'h0, last_bresp}, {30'h0, RESP_SLVERR});
        rchk(OFS_STAT, RST_STAT);
        $display("reset test done");
    endtask
    task t_mbox;
        eng.pulse(32'h8001_01FF, 0, 0);
        rchk(OFS_STAT, 32'h8001_01FF);
        wr(OFS_STAT, 32'h0);
        chk({30'h0, last_bresp}, {30'h0, RESP_OKAY});
        rchk(OFS_STAT, 32'h8001_01FF);
        irq_is(0);
        wr(OFS_INTEN, 32'h0000_0100);
        irq_is(1);
        wr(OFS_STAT, 32'h0000_0100);
        irq_is(0);
        ce <= 0;
        eng.pulse(32'h0000_0200, 0, 0);
        ce <= 1;
        rchk(OFS_STAT, 32'h8001_00FF);
        $display("mailbox test done");
    endtask
    task t_fifo;
        int c;
        wr(OFS_CTRL, 32'h1);
        chk({31'h0, fifo_en}, 32'h1);
        rchk(OFS_STAT, 32'h8001_0000);
        eng.pulse(32'h0000_001F, 1, 1);
        rchk(OFS_STAT, 32'h8001_00C0);
        eng.push();
        rchk(OFS_STAT, 32'h8001_00E0);
        irq_is(0);
        wr(OFS_INTEN, 32'h0000_0020);
        irq_is(1);
        c = eng.clears;
        wr(OFS_STAT, 32'h0);
        wr(OFS_STAT, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(eng.clears), 32'(c));
        eng.inactive <= 1;
        wr(OFS_STAT, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'(eng.clears), 32'(c + 1));
        rchk(OFS_STAT, 32'h8001_00C0);
        irq_is(0);
        wr(OFS_CTRL, 32'h0);
        rchk(OFS_STAT, 32'h8001_0001);
        $display("fifo test done");
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1;
        repeat (2) @(posedge clk);
        t_reset();
        t_mbox();
        t_fifo();
        final_report();
    end
endmodule
`default_nettype wire
